// file: design/mopg_defs.svh
// constants for the margin offset and power-good limit block
`ifndef MOPG_DEFS_SVH
`define MOPG_DEFS_SVH

// ----------------------------------------------------------------
// command codes of the three registers
// ----------------------------------------------------------------
`define MOPG_OFS_MARGIN_HIGH 8'hD5
`define MOPG_OFS_MARGIN_LOW 8'hD6
`define MOPG_OFS_LIMIT_SEL 8'hD7

// ----------------------------------------------------------------
// field widths and legal code ranges
// ----------------------------------------------------------------
`define MOPG_MH_W 5
`define MOPG_ML_W 7
`define MOPG_LS_W 2
`define MOPG_MH_MAX 31
`define MOPG_MH_MIN 0
`define MOPG_ML_MAX (-1)
`define MOPG_ML_MIN (-64)

// ----------------------------------------------------------------
// reset and restore values
// ----------------------------------------------------------------
`define MOPG_MH_RST 16'h0009
`define MOPG_MH_ALT 16'h000F
`define MOPG_ML_RST 16'hFFF7
`define MOPG_ML_ALT 16'hFFF1
`define MOPG_LS_RST 2'h0

// ----------------------------------------------------------------
// thresholds in percent of the reference
// ----------------------------------------------------------------
`define MOPG_PCT_BASE 8'd100
`define MOPG_PG_REL_HI 8'd105
`define MOPG_PG_REL_LO 8'd95
`define MOPG_UVF_0 8'd83
`define MOPG_UVW_0 8'd88
`define MOPG_OVW_0 8'd112
`define MOPG_OVF_0 8'd117
`define MOPG_UVF_1 8'd88
`define MOPG_UVW_1 8'd90
`define MOPG_OVW_1 8'd110
`define MOPG_OVF_1 8'd112
`define MOPG_UVF_2 8'd72
`define MOPG_UVW_2 8'd78
`define MOPG_UVF_3 8'd58
`define MOPG_UVW_3 8'd64

// reference step is 1.953 mV, exponent -9 in linear format
`define MOPG_VOUT_EXP (-9)
// loop scale is an unsigned fraction with this many bits
`define MOPG_SCALE_FRAC 8

`endif

// file: design/mopg_pkg.sv
// types shared by the margin offset and power-good limit block
package mopg_pkg;

  // command handed from the link side to the register side
  typedef struct packed {
    logic [7:0] code;
    logic write;
    logic word;
    logic [15:0] wdata;
  } mopg_cmd_t;

  // answer handed back to the link side
  typedef struct packed {
    logic ack;
    logic [15:0] rdata;
  } mopg_rsp_t;

  // converter phase that picks the reference slew rate
  typedef enum logic [1:0] {
    MOPG_SOFT_START,
    MOPG_STEADY,
    MOPG_TOFF_DELAY,
    MOPG_SOFT_STOP
  } mopg_phase_t;

endpackage

// file: design/mopg_sync.sv
// two flip-flop synchroniser with clock enable
`timescale 1ns/100ps
module mopg_sync
  import mopg_pkg::*;
#(
  parameter int W = 1
)
(
  input wire logic clk, // destination clock
  input wire logic rst_n, // async reset, active low
  input wire logic en, // freezes both stages while low
  input wire logic [W-1:0] d, // level from another domain
  output logic [W-1:0] q // synchronised level
);

  logic [W-1:0] meta;

  // first stage feeds only the second one
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta <= '0;
      q <= '0;
    end
    else if (en)
    begin
      meta <= d;
      q <= meta;
    end
  end

endmodule // mopg_sync

// file: design/mopg_margin_power_good_output.sv
// margin offsets, limit select and power-good with hysteresis
// Operation
// - margin high raises the reference by the high offset
// - loop slave: register access NACKed, data dropped, fault and alert
// - high offset codes 0 to 31, 1.953 mV per code
// - out-of-range offset saturates, alerts, sets CML and invalid data
// - reference including offsets bounded by maximum and minimum output
// - reference slews at a rate chosen by converter phase
// - offset codes are linear with fixed exponent minus nine
// - high register: only low bits 4..0 writable, rest read zero
// - high offset restores to 0009h or 000Fh by option bit
// - margin low lowers the reference by the low offset
// - low offset codes -64 to -1; zero and positive out of range
// - low register: bits 5..0 and sign writable, high byte sign-extended
// - low offset restores to FFF7h or FFF1h by option bit
// - limit select is one byte, bits 1..0 writable, default zero
// - limit select picks UV fault, UV warn, OV warn, OV fault levels
// - power good drops when feedback crosses OV or UV warn level
// - after OV warn trip, power good waits for feedback below 105%
// - after UV warn trip, power good waits for feedback above 95%
// - reference is command times scale plus trim plus gated offsets
`timescale 1ns/100ps
`include "mopg_defs.svh"
module mopg_margin_power_good_output
  import mopg_pkg::*;
(
  input wire logic clk_sys, // device clock
  input wire logic rst_n, // async reset, active low
  input wire logic ce, // clock enable of the device domain
  input wire logic clk_link, // link clock
  input wire logic cmd_valid, // link command request
  input wire mopg_cmd_t cmd, // link command contents
  output logic cmd_busy, // command in flight
  output logic rsp_valid, // answer pulse on the link clock
  output mopg_rsp_t rsp, // answer contents
  input wire logic loop_slave_pin, // strap: device is a loop slave
  input wire logic [1:0] operation_margin, // bit 1 high, bit 0 low
  input wire logic [15:0] vout_command, // output command code
  input wire logic [7:0] vout_scale_loop, // loop scale fraction
  input wire logic [7:0] vref_trim, // signed trim code
  input wire logic [15:0] vout_max, // upper reference bound
  input wire logic [15:0] vout_min, // lower reference bound
  input wire mopg_phase_t phase, // converter phase
  input wire logic [15:0] ton_rise_period, // enabled cycles per step, minus one
  input wire logic [15:0] transition_period, // enabled cycles per step, minus one
  input wire logic [15:0] toff_fall_period, // enabled cycles per step, minus one
  input wire logic restore, // restore defaults pulse
  input wire logic high_restore_option, // pick high restore value
  input wire logic low_restore_option, // pick low restore value
  input wire logic [1:0] limit_select_nv, // stored limit select copy
  input wire logic [15:0] feedback_input, // feedback code
  input wire logic clear_status, // clears fault flags
  output logic [15:0] reference_target, // slewed reference code
  output logic power_good_output, // power good level
  output logic ov_fault, // over-voltage fault level
  output logic uv_fault, // under-voltage fault level
  output logic invalid_command_fault, // sticky invalid command
  output logic cml_invalid_data, // sticky invalid data
  output logic cml_status, // CML summary bit
  output logic smbalert_n // alert, active low
);

  // ----------------------------------------------------------------
  // resets for both domains
  // ----------------------------------------------------------------
  logic rst_sys_n;
  logic rst_link_n;
  logic loop_slave;

  mopg_sync #(.W(1)) u_rst_sys (
    .clk(clk_sys), .rst_n(rst_n), .en(1'b1), .d(1'b1), .q(rst_sys_n));
  mopg_sync #(.W(1)) u_rst_link (
    .clk(clk_link), .rst_n(rst_n), .en(1'b1), .d(1'b1), .q(rst_link_n));
  mopg_sync #(.W(1)) u_strap (
    .clk(clk_sys), .rst_n(rst_sys_n), .en(ce), .d(loop_slave_pin),
    .q(loop_slave));

  // ----------------------------------------------------------------
  // link side: hold the command, toggle a request, wait for the answer
  // ----------------------------------------------------------------
  mopg_cmd_t cmd_hold;
  mopg_rsp_t rsp_q;
  logic req_tgl;
  logic ack_tgl;
  logic ack_sync;
  logic ack_seen;
  logic req_sync;
  logic req_seen;

  mopg_sync #(.W(1)) u_ack (
    .clk(clk_link), .rst_n(rst_link_n), .en(1'b1), .d(ack_tgl),
    .q(ack_sync));

  // command word stays frozen while busy, so the far side samples it clean
  always_ff @(posedge clk_link or negedge rst_link_n)
  begin
    if (!rst_link_n)
    begin
      cmd_hold <= '0;
      req_tgl <= 1'b0;
      cmd_busy <= 1'b0;
    end
    else if (cmd_valid && !cmd_busy)
    begin
      cmd_hold <= cmd;
      req_tgl <= !req_tgl;
      cmd_busy <= 1'b1;
    end
    else if (ack_sync != ack_seen)
      cmd_busy <= 1'b0;
  end

  // answer is copied once the acknowledge toggle has settled
  always_ff @(posedge clk_link or negedge rst_link_n)
  begin
    if (!rst_link_n)
    begin
      ack_seen <= 1'b0;
      rsp_valid <= 1'b0;
      rsp <= '0;
    end
    else
    begin
      ack_seen <= ack_sync;
      rsp_valid <= (ack_sync != ack_seen);
      if (ack_sync != ack_seen)
        rsp <= rsp_q;
    end
  end

  // ----------------------------------------------------------------
  // device side: command decode
  // ----------------------------------------------------------------
  logic req_take;
  logic is_mh;
  logic is_ml;
  logic is_ls;
  logic width_ok;
  logic [`MOPG_MH_W-1:0] mh;
  logic [`MOPG_ML_W-1:0] ml;
  logic [`MOPG_LS_W-1:0] limit_select;
  logic [`MOPG_MH_W-1:0] next_mh;
  logic [`MOPG_ML_W-1:0] next_ml;
  logic mh_bad;
  logic ml_bad;
  logic [15:0] mh_read;
  logic [15:0] ml_read;

  mopg_sync #(.W(1)) u_req (
    .clk(clk_sys), .rst_n(rst_sys_n), .en(ce), .d(req_tgl), .q(req_sync));

  assign req_take = ce && (req_sync != req_seen);
  assign is_mh = (cmd_hold.code == `MOPG_OFS_MARGIN_HIGH);
  assign is_ml = (cmd_hold.code == `MOPG_OFS_MARGIN_LOW);
  assign is_ls = (cmd_hold.code == `MOPG_OFS_LIMIT_SEL);
  // margins are word commands, limit select a byte command
  assign width_ok = ((is_mh || is_ml) && cmd_hold.word) ||
                    (is_ls && !cmd_hold.word);
  // readback carries the fixed bits as they stand
  assign mh_read = {{(16-`MOPG_MH_W){1'b0}}, mh};
  assign ml_read = {{(16-`MOPG_ML_W){ml[`MOPG_ML_W-1]}}, ml};

  // saturate out-of-range codes to the nearer legal end
  always_comb
  begin
    next_mh = cmd_hold.wdata[`MOPG_MH_W-1:0];
    next_ml = cmd_hold.wdata[`MOPG_ML_W-1:0];
    mh_bad = 1'b0;
    ml_bad = 1'b0;
    if ($signed(cmd_hold.wdata) > `MOPG_MH_MAX)
    begin
      next_mh = `MOPG_MH_W'(`MOPG_MH_MAX);
      mh_bad = 1'b1;
    end
    else if ($signed(cmd_hold.wdata) < `MOPG_MH_MIN)
    begin
      next_mh = `MOPG_MH_W'(`MOPG_MH_MIN);
      mh_bad = 1'b1;
    end
    if ($signed(cmd_hold.wdata) > `MOPG_ML_MAX)
    begin
      next_ml = `MOPG_ML_W'(`MOPG_ML_MAX);
      ml_bad = 1'b1;
    end
    else if ($signed(cmd_hold.wdata) < `MOPG_ML_MIN)
    begin
      next_ml = `MOPG_ML_W'(`MOPG_ML_MIN);
      ml_bad = 1'b1;
    end
  end

  // registers: a write after a restore in the same cycle wins
  always_ff @(posedge clk_sys or negedge rst_sys_n)
  begin
    if (!rst_sys_n)
    begin
      mh <= `MOPG_MH_W'(`MOPG_MH_RST);
      ml <= `MOPG_ML_W'(`MOPG_ML_RST);
      limit_select <= `MOPG_LS_RST;
    end
    else if (ce)
    begin
      if (restore)
      begin
        mh <= high_restore_option ? `MOPG_MH_W'(`MOPG_MH_ALT) :
                                    `MOPG_MH_W'(`MOPG_MH_RST);
        ml <= low_restore_option ? `MOPG_ML_W'(`MOPG_ML_ALT) :
                                   `MOPG_ML_W'(`MOPG_ML_RST);
        limit_select <= limit_select_nv;
      end
      // a loop slave discards the data
      if (req_take && cmd_hold.write && width_ok && !loop_slave)
      begin
        if (is_mh)
          mh <= next_mh;
        if (is_ml)
          ml <= next_ml;
        if (is_ls)
          limit_select <= cmd_hold.wdata[`MOPG_LS_W-1:0];
      end
    end
  end

  // answer and acknowledge toggle back to the link
  always_ff @(posedge clk_sys or negedge rst_sys_n)
  begin
    if (!rst_sys_n)
    begin
      req_seen <= 1'b0;
      ack_tgl <= 1'b0;
      rsp_q <= '0;
    end
    else if (req_take)
    begin
      req_seen <= req_sync;
      ack_tgl <= !ack_tgl;
      rsp_q.ack <= width_ok && !loop_slave;
      rsp_q.rdata <= is_mh ? mh_read :
                     is_ml ? ml_read :
                     {14'h0000, limit_select};
    end
  end

  // ----------------------------------------------------------------
  // fault flags; a new event beats a clear in the same cycle
  // ----------------------------------------------------------------
  logic ivc_set;
  logic ivd_set;

  assign ivc_set = req_take && (is_mh || is_ml || is_ls) &&
                   (loop_slave || !width_ok);
  assign ivd_set = req_take && cmd_hold.write && width_ok && !loop_slave &&
                   ((is_mh && mh_bad) || (is_ml && ml_bad));

  always_ff @(posedge clk_sys or negedge rst_sys_n)
  begin
    if (!rst_sys_n)
    begin
      invalid_command_fault <= 1'b0;
      cml_invalid_data <= 1'b0;
    end
    else if (ce)
    begin
      invalid_command_fault <= ivc_set ||
                               (invalid_command_fault && !clear_status);
      cml_invalid_data <= ivd_set || (cml_invalid_data && !clear_status);
    end
  end

  assign cml_status = invalid_command_fault || cml_invalid_data;
  assign smbalert_n = !cml_status;

  // ----------------------------------------------------------------
  // reference target: sum, bound, then slew
  // ----------------------------------------------------------------
  logic signed [23:0] ref_sum;
  logic [15:0] target;
  logic [15:0] step_period;
  logic [15:0] step_cnt;
  logic step_now;

  // codes are 1.953 mV steps, exponent -9 is fixed
  always_comb
  begin
    ref_sum = $signed({8'h00, 16'((32'(vout_command) *
              32'(vout_scale_loop)) >> `MOPG_SCALE_FRAC)})
            + 24'($signed(vref_trim))
            + (operation_margin[1] ? 24'($signed({1'b0, mh})) : 24'sd0)
            + (operation_margin[0] ? 24'($signed(ml)) : 24'sd0);
    if (ref_sum > $signed({8'h00, vout_max}))
      target = vout_max;
    else if (ref_sum < $signed({8'h00, vout_min}))
      target = vout_min;
    else
      target = ref_sum[15:0];
  end

  // slew period follows the converter phase
  always_comb
  begin
    unique case (phase)
      MOPG_SOFT_START: step_period = ton_rise_period;
      MOPG_STEADY: step_period = transition_period;
      MOPG_TOFF_DELAY: step_period = transition_period;
      MOPG_SOFT_STOP: step_period = toff_fall_period;
    endcase
  end

  assign step_now = ce && (reference_target != target) &&
                    (step_cnt >= step_period);

  // one code per period, so a large jump never overshoots
  always_ff @(posedge clk_sys or negedge rst_sys_n)
  begin
    if (!rst_sys_n)
    begin
      step_cnt <= 16'h0000;
      reference_target <= 16'h0000;
    end
    else if (ce)
    begin
      step_cnt <= step_now ? 16'h0000 : step_cnt + 16'h0001;
      if (step_now)
        reference_target <= (reference_target < target) ?
                            reference_target + 16'h0001 :
                            reference_target - 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // thresholds and power good
  // ----------------------------------------------------------------
  logic [7:0] pct_uvf;
  logic [7:0] pct_uvw;
  logic [7:0] pct_ovw;
  logic [7:0] pct_ovf;
  logic [23:0] lvl_uvf;
  logic [23:0] lvl_uvw;
  logic [23:0] lvl_ovw;
  logic [23:0] lvl_ovf;
  logic [23:0] lvl_rel_hi;
  logic [23:0] lvl_rel_lo;
  logic [23:0] fb_scaled;
  logic ov_trip;
  logic uv_trip;

  always_comb
  begin
    unique case (limit_select)
      2'h0: {pct_uvf, pct_uvw, pct_ovw, pct_ovf} =
        {`MOPG_UVF_0, `MOPG_UVW_0, `MOPG_OVW_0, `MOPG_OVF_0};
      2'h1: {pct_uvf, pct_uvw, pct_ovw, pct_ovf} =
        {`MOPG_UVF_1, `MOPG_UVW_1, `MOPG_OVW_1, `MOPG_OVF_1};
      2'h2: {pct_uvf, pct_uvw, pct_ovw, pct_ovf} =
        {`MOPG_UVF_2, `MOPG_UVW_2, `MOPG_OVW_0, `MOPG_OVF_0};
      2'h3: {pct_uvf, pct_uvw, pct_ovw, pct_ovf} =
        {`MOPG_UVF_3, `MOPG_UVW_3, `MOPG_OVW_0, `MOPG_OVF_0};
    endcase
  end

  // compare in percent units, so no divider is needed
  assign fb_scaled = 24'(feedback_input) * 24'(`MOPG_PCT_BASE);

  // levels are recomputed on every enabled cycle from the slewed reference
  always_ff @(posedge clk_sys or negedge rst_sys_n)
  begin
    if (!rst_sys_n)
    begin
      lvl_uvf <= 24'h000000;
      lvl_uvw <= 24'h000000;
      lvl_ovw <= 24'h000000;
      lvl_ovf <= 24'h000000;
      lvl_rel_hi <= 24'h000000;
      lvl_rel_lo <= 24'h000000;
    end
    else if (ce)
    begin
      lvl_uvf <= 24'(reference_target) * 24'(pct_uvf);
      lvl_uvw <= 24'(reference_target) * 24'(pct_uvw);
      lvl_ovw <= 24'(reference_target) * 24'(pct_ovw);
      lvl_ovf <= 24'(reference_target) * 24'(pct_ovf);
      lvl_rel_hi <= 24'(reference_target) * 24'(`MOPG_PG_REL_HI);
      lvl_rel_lo <= 24'(reference_target) * 24'(`MOPG_PG_REL_LO);
    end
  end

  // trips set on the warn level and clear only past the release level
  always_ff @(posedge clk_sys or negedge rst_sys_n)
  begin
    if (!rst_sys_n)
    begin
      ov_trip <= 1'b0;
      uv_trip <= 1'b1;
      ov_fault <= 1'b0;
      uv_fault <= 1'b0;
    end
    else if (ce)
    begin
      if (fb_scaled > lvl_ovw)
        ov_trip <= 1'b1;
      else if (fb_scaled < lvl_rel_hi)
        ov_trip <= 1'b0;
      if (fb_scaled < lvl_uvw)
        uv_trip <= 1'b1;
      else if (fb_scaled > lvl_rel_lo)
        uv_trip <= 1'b0;
      ov_fault <= fb_scaled > lvl_ovf;
      uv_fault <= fb_scaled < lvl_uvf;
    end
  end

  assign power_good_output = !ov_trip && !uv_trip;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_sys_n);

  mh_clamp_a: assert property (req_take && cmd_hold.write && is_mh &&
    width_ok && !loop_slave && $signed(cmd_hold.wdata) > 31
    |=> mh == 5'd31 && cml_invalid_data && !smbalert_n)
    else $error("high offset not saturated");
  ml_sign_a: assert property (ml[`MOPG_ML_W-1] &&
    ml_read[15:8] == 8'hFF) else $error("low offset not negative");
  slave_nack_a: assert property (req_take && loop_slave && is_ml
    |=> !rsp_q.ack && invalid_command_fault && $stable(ml) || $past(restore))
    else $error("loop slave access not refused");
  restore_hi_a: assert property (ce && restore && !req_take &&
    high_restore_option |=> mh_read == 16'h000F)
    else $error("high restore value wrong");
  restore_lo_a: assert property (ce && restore && !req_take &&
    !low_restore_option |=> ml_read == 16'hFFF7)
    else $error("low restore value wrong");
  target_bound_a: assert property (vout_min <= vout_max |->
    target <= vout_max && target >= vout_min)
    else $error("target outside bounds");
  slew_up_a: assert property (step_now && reference_target < target
    |=> reference_target == $past(reference_target) + 16'h0001)
    else $error("reference slew step wrong");
  pg_drop_a: assert property (ce && fb_scaled > lvl_ovw
    |=> !power_good_output) else $error("power good not dropped");
  pg_hyst_a: assert property (ov_trip && ce &&
    fb_scaled >= lvl_rel_hi |=> ov_trip)
    else $error("OV trip released early");
  uv_hyst_a: assert property (uv_trip && ce &&
    fb_scaled <= lvl_rel_lo |=> uv_trip)
    else $error("UV trip released early");

  ov_trip_c: cover property (ov_trip ##1 !ov_trip);
  uv_trip_c: cover property (!uv_trip ##1 uv_trip);
  slave_c: cover property (ivc_set && loop_slave);
  clamp_c: cover property (ivd_set);

endmodule // mopg_margin_power_good_output

// file: sim/mopg_host_model.sv
// host-side stand-in issuing one register command at a time
`timescale 1ns/100ps
module mopg_host_model
  import mopg_pkg::*;
(
  input wire logic clk_link, // link clock
  input wire logic cmd_busy, // command in flight
  input wire logic rsp_valid, // answer pulse
  input wire mopg_rsp_t rsp, // answer contents
  output logic cmd_valid, // request
  output mopg_cmd_t cmd // request contents
);
  initial
  begin
    cmd_valid = 1'h0;
    cmd = '0;
  end

  // ----------------------------------------------------------------
  // one whole transfer, word or byte as the word bit of the command asks
  // ----------------------------------------------------------------
  // lines are held until taken, then inverted so stale data is useless
  task automatic xfer(input mopg_cmd_t c, output mopg_rsp_t r,
    output logic to);
    int n;
    begin
      n = 0;
      @(posedge clk_link);
      cmd_valid <= 1'h1;
      cmd <= c;
      do
      begin
        @(posedge clk_link);
        n++;
      end
      while (cmd_busy !== 1'h0 && n < 40);
      cmd_valid <= 1'h0;
      cmd <= ~c;
      do
      begin
        @(posedge clk_link);
        n++;
      end
      while (rsp_valid !== 1'h1 && n < 80);
      r = rsp;
      to = (n >= 80);
    end
  endtask
endmodule // mopg_host_model

// file: sim/test_margin_offset_and_power_good_output_limits.sv
// register, reference and power-good bench for the margin block
`timescale 1ns/100ps
`include "mopg_defs.svh"
module test_margin_offset_and_power_good_output_limits
  import mopg_pkg::*;
;
  localparam logic [7:0] MH = `MOPG_OFS_MARGIN_HIGH;
  localparam logic [7:0] ML = `MOPG_OFS_MARGIN_LOW;
  localparam logic [7:0] LS = `MOPG_OFS_LIMIT_SEL;
  logic clk_sys = 1'h0, clk_link = 1'h0, rst_n = 1'h0, ce = 1'h1;
  logic cmd_valid, cmd_busy, rsp_valid;
  mopg_cmd_t cmd;
  mopg_rsp_t rsp;
  logic loop_slave_pin = 1'h0, restore = 1'h0, clear_status = 1'h0;
  logic high_restore_option = 1'h0, low_restore_option = 1'h0;
  logic [1:0] operation_margin = 2'h0, limit_select_nv = 2'h2;
  logic [15:0] vout_command = 16'h0100, vout_max = 16'hFFFF;
  logic [15:0] vout_min = 16'h0, feedback_input = 16'h0;
  logic [15:0] ton_rise_period = 16'h0, transition_period = 16'h0;
  logic [15:0] toff_fall_period = 16'h0;
  logic [7:0] vout_scale_loop = 8'h80, vref_trim = 8'h0;
  mopg_phase_t phase = MOPG_STEADY;
  logic [15:0] reference_target;
  logic power_good_output, ov_fault, uv_fault, invalid_command_fault;
  logic cml_invalid_data, cml_status, smbalert_n;
  int num_errors = 0, total_checks = 0, cycles = 0;
  logic [15:0] fbv [9] = '{16'h0080, 16'h008F, 16'h0090, 16'h0087,
    16'h0086, 16'h0071, 16'h0070, 16'h0079, 16'h007A};
  logic pge [9] = '{1'h1, 1'h1, 1'h0, 1'h0, 1'h1, 1'h1, 1'h0, 1'h0, 1'h1};

  mopg_margin_power_good_output uut (.clk_sys, .rst_n, .ce, .clk_link, .cmd_valid,
    .cmd, .cmd_busy, .rsp_valid, .rsp, .loop_slave_pin, .operation_margin,
    .vout_command, .vout_scale_loop, .vref_trim, .vout_max, .vout_min,
    .phase, .ton_rise_period, .transition_period, .toff_fall_period,
    .restore, .high_restore_option, .low_restore_option, .limit_select_nv,
    .feedback_input, .clear_status, .reference_target, .power_good_output,
    .ov_fault, .uv_fault, .invalid_command_fault, .cml_invalid_data,
    .cml_status, .smbalert_n);
  mopg_host_model host (.clk_link, .cmd_busy, .rsp_valid, .rsp,
    .cmd_valid, .cmd);

  // ----------------------------------------------------------------
  // clocks, hang guard and shared tasks
  // ----------------------------------------------------------------
  initial
  begin
    forever #12.5 clk_sys = ~clk_sys;
  end
  // link clock offset so its edges wander against the device clock
  initial
  begin
    #7;
    forever #24 clk_link = ~clk_link;
  end
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      num_errors = num_errors + 1;
      wrap_up;
    end
  end
  task automatic wrap_up;
    if (num_errors == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    total_checks++;
    if (s !== e)
    begin
      num_errors++;
      $display("mismatch %0t: got %h want %h", $time, s, e);
    end
  endtask
  task automatic chkb(input logic s, input logic e);
    chk({15'h0, s}, {15'h0, e});
  endtask
  task automatic sys(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // one command; read data checked only on acknowledged reads
  task automatic tx(input logic [7:0] c, input logic w, input logic wd,
    input logic [15:0] d, input logic ea, input logic [15:0] er);
    mopg_rsp_t r;
    logic to;
    host.xfer('{c, w, wd, d}, r, to);
    chkb(to, 1'h0);
    chkb(r.ack, ea);
    if (!w && ea)
      chk(r.rdata, er);
  endtask
  task automatic clr;
    sys(1);
    clear_status <= 1'h1;
    sys(1);
    clear_status <= 1'h0;
    sys(3);
  endtask
  // restore pulse, option bits set on the same device edge
  task automatic rest(input logic hi, input logic lo);
    sys(1);
    high_restore_option <= hi;
    low_restore_option <= lo;
    restore <= 1'h1;
    sys(1);
    restore <= 1'h0;
    sys(3);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    sys(10);
    rst_n <= 1'h1;
    sys(8);
    chkb(smbalert_n, 1'h1);
    tx(MH, 0, 1, 0, 1, 16'h0009);
    tx(ML, 0, 1, 0, 1, 16'hFFF7);
    tx(LS, 0, 0, 0, 1, 16'h0000);
    tx(MH, 1, 1, 16'h0014, 1, 0);
    tx(MH, 0, 1, 0, 1, 16'h0014);
    chkb(smbalert_n, 1'h1);
    tx(MH, 1, 1, 16'h0020, 1, 0);
    tx(MH, 0, 1, 0, 1, 16'h001F);
    sys(2);
    chkb(cml_invalid_data & cml_status & ~smbalert_n, 1'h1);
    clr;
    chkb(smbalert_n, 1'h1);
    tx(ML, 1, 1, 16'hFFC0, 1, 0);
    tx(ML, 0, 1, 0, 1, 16'hFFC0);
    tx(ML, 1, 1, 16'h0005, 1, 0);
    tx(ML, 0, 1, 0, 1, 16'hFFFF);
    tx(ML, 1, 1, 16'hFF80, 1, 0);
    tx(ML, 0, 1, 0, 1, 16'hFFC0);
    tx(LS, 1, 0, 16'h00FF, 1, 0);
    tx(LS, 0, 0, 0, 1, 16'h0003);
    tx(LS, 0, 1, 0, 0, 0);
    sys(2);
    chkb(invalid_command_fault, 1'h1);
    clr;
    tx(8'hD0, 0, 1, 0, 0, 0);
    chkb(invalid_command_fault, 1'h0);
    rest(1'h1, 1'h1);
    tx(MH, 0, 1, 0, 1, 16'h000F);
    tx(ML, 0, 1, 0, 1, 16'hFFF1);
    tx(LS, 0, 0, 0, 1, 16'h0002);
    rest(1'h0, 1'h0);
    tx(MH, 0, 1, 0, 1, 16'h0009);
    tx(ML, 0, 1, 0, 1, 16'hFFF7);
    tx(MH, 1, 1, 16'h001F, 1, 0);
    tx(ML, 1, 1, 16'hFFC0, 1, 0);
    tx(LS, 1, 0, 16'h0000, 1, 0);
    sys(300);
    chk(reference_target, 16'h0080);
    operation_margin <= 2'h2;
    sys(300);
    chk(reference_target, 16'h009F);
    operation_margin <= 2'h1;
    sys(300);
    chk(reference_target, 16'h0040);
    vout_min <= 16'h0050;
    sys(300);
    chk(reference_target, 16'h0050);
    // slow steady rate, then the fast soft-start rate takes over
    transition_period <= 16'h0009;
    operation_margin <= 2'h0;
    vout_min <= 16'h0;
    sys(100);
    chkb(reference_target > 80 && reference_target < 128, 1'h1);
    phase <= MOPG_SOFT_START;
    sys(60);
    chk(reference_target, 16'h0080);
    phase <= MOPG_STEADY;
    for (int i = 0; i < 9; i++)
    begin
      feedback_input <= fbv[i];
      sys(5);
      chkb(power_good_output, pge[i]);
    end
    tx(LS, 1, 0, 16'h0001, 1, 0);
    sys(1);
    feedback_input <= 16'h008D;
    sys(5);
    chkb(power_good_output, 1'h0);
    feedback_input <= 16'h0090;
    sys(5);
    chkb(ov_fault, 1'h1);
    tx(LS, 1, 0, 16'h0003, 1, 0);
    sys(1);
    feedback_input <= 16'h004B;
    clr;
    chkb(uv_fault, 1'h0);
    feedback_input <= 16'h004A;
    sys(5);
    chkb(uv_fault, 1'h1);
    // frozen while the enable is low, then trim and upper bound apply
    ce <= 1'h0;
    operation_margin <= 2'h2;
    vref_trim <= 8'hFE;
    vout_max <= 16'h0090;
    sys(20);
    chk(reference_target, 16'h0080);
    ce <= 1'h1;
    sys(200);
    chk(reference_target, 16'h0090);
    phase <= MOPG_SOFT_STOP;
    operation_margin <= 2'h0;
    sys(30);
    chk(reference_target, 16'h007E);
    clr;
    loop_slave_pin <= 1'h1;
    sys(4);
    tx(MH, 1, 1, 16'h0002, 0, 0);
    tx(ML, 0, 1, 0, 0, 0);
    sys(2);
    chkb(invalid_command_fault & ~smbalert_n, 1'h1);
    loop_slave_pin <= 1'h0;
    sys(4);
    tx(MH, 0, 1, 0, 1, 16'h001F);
    wrap_up;
  end
endmodule // test_margin_offset_and_power_good_output_limits
